// ===== rtl/lock_cmd_pkg.sv
// Constants, command codes and carrier types of the sector lock command engine
package lock_cmd_pkg;

   localparam logic [7:0] OP_LOCK_RD = 8'h3D;
   localparam logic [7:0] OP_LOCK_RD_WIDE = 8'hE0;
   localparam logic [7:0] OP_LOCK = 8'h36;
   localparam logic [7:0] OP_LOCK_WIDE = 8'hE1;
   localparam logic [7:0] OP_UNLOCK = 8'h39;
   localparam logic [7:0] OP_UNLOCK_WIDE = 8'hE2;
   localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
   localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
   localparam logic [7:0] OP_SET_PTR = 8'hFB;
   localparam logic [7:0] OP_SET_PTR_WIDE = 8'hE3;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

   localparam logic [5:0] OPCODE_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
   localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
   localparam logic [5:0] STEP_SINGLE = 6'h01;
   localparam logic [5:0] STEP_QUAD = 6'h04;
   localparam int ADDR_MSB_NARROW = 23;
   localparam int ADDR_MSB_WIDE = 31;

   localparam logic LOCKED = 1'b0;
   localparam logic UNLOCKED = 1'b1;
   localparam logic LOCK_BIT_RESET = 1'b1;
   localparam logic [7:0] LOCK_REG_LOCKED = 8'h00;
   localparam logic [7:0] LOCK_REG_UNLOCKED = 8'hFF;
   localparam logic [31:0] POINTER_RESET = 32'h0000_0000;

   localparam logic [3:0] OE_SINGLE = 4'h2;
   localparam logic [3:0] OE_QUAD = 4'hF;
   localparam logic [3:0] OE_OFF = 4'h0;

   localparam int CLK_NS = 40;
   localparam int OP_TIME_NS = 1000;

   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_LOCK_RD = 3'b001,
      CMD_LOCK = 3'b010,
      CMD_UNLOCK = 3'b011,
      CMD_GLOBAL_LOCK = 3'b100,
      CMD_GLOBAL_UNLOCK = 3'b101,
      CMD_SET_PTR = 3'b110,
      CMD_WRITE_ENABLE = 3'b111
   } cmd_e;

   typedef enum logic [2:0] {
      PH_OPCODE = 3'b000,
      PH_ADDR = 3'b001,
      PH_DATA = 3'b010,
      PH_DONE = 3'b011,
      PH_DROP = 3'b100
   } phase_e;

   typedef struct packed {
      logic addr_wide;
      logic quad;
      logic scheme_individual;
      logic suspended;
      logic nonvolatile_lock_bit;
      logic supply_lockdown;
      logic password_select;
   } cfg_s;

   typedef struct packed {
      logic busy;
      logic write_enable_latch;
      logic prog_error;
   } status_s;

endpackage

// ===== rtl/lock_cmd_engine.sv
// Sector lock, global lock and pointer region command engine of a serial flash
// What this block does
// - Decode lock-state read, both opcodes.
// - Opcode bits taken on serial clock rising.
// - Read returns 8-bit lock register, falling edges.
// - Extra clocks repeat same register, no increment.
// - Address length 24 or 32 per setting.
// - Wide opcodes always take 32-bit address.
// - Sector lock clears addressed lock bit.
// - Sector unlock sets addressed lock bit.
// - Busy high during sector lock.
// - Busy high during sector unlock.
// - Global lock clears all lock bits.
// - Global unlock sets all lock bits.
// - Global commands need select rise after bit eight.
// - Busy high during global commands.
// - Quad mode moves everything on four lines.
// - Pointer command ignored while suspended.
// - Pointer command ignored by protection bits.
// - Pointer command needs write enable latch.
// - Pointer select rise rule, busy, clears latch.
// - Failed pointer set raises program error.
// - Lock commands need individual scheme selected.
// - One volatile lock bit per sector.
`timescale 1ns/1ps
`default_nettype none

module lock_cmd_engine #(
   parameter int NUM_SECTORS = 256,
   parameter int SECTOR_SHIFT = 16,
   parameter int OP_TIME_NS = lock_cmd_pkg::OP_TIME_NS
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic [3:0] i_io,
   input wire lock_cmd_pkg::cfg_s i_cfg,
   input wire logic i_ptr_fail,
   input wire logic i_error_clear,
   output logic [3:0] o_io_out,
   output logic [3:0] o_io_oe,
   output var lock_cmd_pkg::status_s o_status,
   output logic [NUM_SECTORS-1:0] o_lock_bits,
   output logic [31:0] o_pointer_region
);

   localparam int SECT_W = $clog2(NUM_SECTORS);
   localparam int OP_CYC_RAW = (OP_TIME_NS + lock_cmd_pkg::CLK_NS - 1) / lock_cmd_pkg::CLK_NS;
   localparam int OP_CYC = (OP_CYC_RAW < 1) ? 1 : OP_CYC_RAW;
   localparam int OP_LAST = OP_CYC - 1;

   function automatic logic [SECT_W-1:0] sector_of(input logic [31:0] a);
      sector_of = a[SECTOR_SHIFT +: SECT_W];
   endfunction

   function automatic lock_cmd_pkg::cmd_e decode(input logic [7:0] op);
      if (op == lock_cmd_pkg::OP_LOCK_RD || op == lock_cmd_pkg::OP_LOCK_RD_WIDE) begin
         decode = lock_cmd_pkg::CMD_LOCK_RD;
      end else if (op == lock_cmd_pkg::OP_LOCK || op == lock_cmd_pkg::OP_LOCK_WIDE) begin
         decode = lock_cmd_pkg::CMD_LOCK;
      end else if (op == lock_cmd_pkg::OP_UNLOCK || op == lock_cmd_pkg::OP_UNLOCK_WIDE) begin
         decode = lock_cmd_pkg::CMD_UNLOCK;
      end else if (op == lock_cmd_pkg::OP_GLOBAL_LOCK) begin
         decode = lock_cmd_pkg::CMD_GLOBAL_LOCK;
      end else if (op == lock_cmd_pkg::OP_GLOBAL_UNLOCK) begin
         decode = lock_cmd_pkg::CMD_GLOBAL_UNLOCK;
      end else if (op == lock_cmd_pkg::OP_SET_PTR || op == lock_cmd_pkg::OP_SET_PTR_WIDE) begin
         decode = lock_cmd_pkg::CMD_SET_PTR;
      end else if (op == lock_cmd_pkg::OP_WRITE_ENABLE) begin
         decode = lock_cmd_pkg::CMD_WRITE_ENABLE;
      end else begin
         decode = lock_cmd_pkg::CMD_NONE;
      end
   endfunction

   // Synchroniser stages for chip select, serial clock and data lines
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic sck_prev;
   logic cs_prev;

   lock_cmd_pkg::phase_e phase;
   lock_cmd_pkg::phase_e next_phase;
   lock_cmd_pkg::cmd_e cur_cmd;
   lock_cmd_pkg::cmd_e busy_cmd;
   logic [5:0] bit_cnt;
   logic [5:0] cur_len;
   logic [31:0] in_sh;
   logic [31:0] cmd_addr;
   logic [7:0] rot;
   logic [15:0] timer;
   logic [NUM_SECTORS-1:0] lock_bits;
   lock_cmd_pkg::status_s status;

   wire logic cs_s = sync2[5];
   wire logic sck_s = sync2[4];
   wire logic [3:0] io_s = sync2[3:0];
   wire logic sck_rise = sck_s & ~sck_prev & ~cs_s;
   wire logic sck_fall = ~sck_s & sck_prev & ~cs_s;
   wire logic cs_rise = cs_s & ~cs_prev;
   wire logic quad = i_cfg.quad;

   wire logic [5:0] step = quad ? lock_cmd_pkg::STEP_QUAD : lock_cmd_pkg::STEP_SINGLE;
   wire logic [5:0] next_cnt = 6'(bit_cnt + step);
   wire logic [31:0] next_in_sh = quad ? {in_sh[27:0], io_s} : {in_sh[30:0], io_s[0]};
   wire logic [7:0] opcode = next_in_sh[7:0];
   wire lock_cmd_pkg::cmd_e dec_cmd = decode(opcode);
   wire logic wide_op = (opcode == lock_cmd_pkg::OP_LOCK_RD_WIDE)
      || (opcode == lock_cmd_pkg::OP_LOCK_WIDE) || (opcode == lock_cmd_pkg::OP_UNLOCK_WIDE)
      || (opcode == lock_cmd_pkg::OP_SET_PTR_WIDE);
   wire logic [5:0] dec_len = (wide_op || i_cfg.addr_wide) ? lock_cmd_pkg::ADDR_BITS_WIDE
      : lock_cmd_pkg::ADDR_BITS_NARROW;
   wire logic opcode_done = sck_rise && (phase == lock_cmd_pkg::PH_OPCODE)
      && (next_cnt == lock_cmd_pkg::OPCODE_BITS);
   wire logic addr_done = sck_rise && (phase == lock_cmd_pkg::PH_ADDR) && (next_cnt == cur_len);
   wire logic [31:0] addr_word = (cur_len == lock_cmd_pkg::ADDR_BITS_WIDE) ? next_in_sh
      : {8'h00, next_in_sh[lock_cmd_pkg::ADDR_MSB_NARROW:0]};

   wire logic lock_family = (dec_cmd == lock_cmd_pkg::CMD_LOCK_RD)
      || (dec_cmd == lock_cmd_pkg::CMD_LOCK) || (dec_cmd == lock_cmd_pkg::CMD_UNLOCK)
      || (dec_cmd == lock_cmd_pkg::CMD_GLOBAL_LOCK)
      || (dec_cmd == lock_cmd_pkg::CMD_GLOBAL_UNLOCK);
   wire logic ptr_allowed = ~i_cfg.suspended
      && i_cfg.nonvolatile_lock_bit && i_cfg.supply_lockdown && i_cfg.password_select
      && status.write_enable_latch;
   wire logic cmd_ok = ~status.busy && ((lock_family && i_cfg.scheme_individual)
      || ((dec_cmd == lock_cmd_pkg::CMD_SET_PTR) && ptr_allowed)
      || (dec_cmd == lock_cmd_pkg::CMD_WRITE_ENABLE));
   wire logic needs_addr = (dec_cmd == lock_cmd_pkg::CMD_LOCK_RD)
      || (dec_cmd == lock_cmd_pkg::CMD_LOCK) || (dec_cmd == lock_cmd_pkg::CMD_UNLOCK)
      || (dec_cmd == lock_cmd_pkg::CMD_SET_PTR);

   // Select rise counts only when it comes straight after the last bit
   wire logic exec = cs_rise && (phase == lock_cmd_pkg::PH_DONE);
   wire logic exec_write_enable_cmd = exec && (cur_cmd == lock_cmd_pkg::CMD_WRITE_ENABLE);
   wire logic exec_timed = exec && (cur_cmd != lock_cmd_pkg::CMD_WRITE_ENABLE)
      && (cur_cmd != lock_cmd_pkg::CMD_LOCK_RD);
   wire logic op_end = status.busy && (timer == 16'h0000);
   wire logic ptr_end = op_end && (busy_cmd == lock_cmd_pkg::CMD_SET_PTR);
   wire logic [SECT_W-1:0] sec_idx = sector_of(cmd_addr);
   wire logic [7:0] rd_value = lock_bits[sector_of(addr_word)] ? lock_cmd_pkg::LOCK_REG_UNLOCKED
      : lock_cmd_pkg::LOCK_REG_LOCKED;
   wire logic rd_shift = sck_fall && (phase == lock_cmd_pkg::PH_DATA);

   always_comb begin
      next_phase = phase;
      if (cs_s) begin
         next_phase = lock_cmd_pkg::PH_OPCODE;
      end else if (sck_rise) begin
         case (phase)
            lock_cmd_pkg::PH_OPCODE: begin
               if (opcode_done) begin
                  if (!cmd_ok) begin
                     next_phase = lock_cmd_pkg::PH_DROP;
                  end else if (needs_addr) begin
                     next_phase = lock_cmd_pkg::PH_ADDR;
                  end else begin
                     next_phase = lock_cmd_pkg::PH_DONE;
                  end
               end
            end
            lock_cmd_pkg::PH_ADDR: begin
               if (addr_done) begin
                  next_phase = (cur_cmd == lock_cmd_pkg::CMD_LOCK_RD) ? lock_cmd_pkg::PH_DATA
                     : lock_cmd_pkg::PH_DONE;
               end
            end
            lock_cmd_pkg::PH_DONE: begin
               next_phase = lock_cmd_pkg::PH_DROP;
            end
            default: begin
               next_phase = phase;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= 6'h20;
         sync2 <= 6'h20;
         sck_prev <= 1'b0;
         cs_prev <= 1'b1;
      end else begin
         sync1 <= {i_cs_n, i_sck, i_io};
         sync2 <= sync1;
         sck_prev <= sck_s;
         cs_prev <= cs_s;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         phase <= lock_cmd_pkg::PH_OPCODE;
         bit_cnt <= 6'h00;
         in_sh <= 32'h0000_0000;
      end else begin
         phase <= next_phase;
         if (cs_s || opcode_done) begin
            bit_cnt <= 6'h00;
         end else if (sck_rise && (phase == lock_cmd_pkg::PH_OPCODE
               || phase == lock_cmd_pkg::PH_ADDR)) begin
            bit_cnt <= next_cnt;
         end
         if (sck_rise) begin
            in_sh <= next_in_sh;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cur_cmd <= lock_cmd_pkg::CMD_NONE;
         cur_len <= lock_cmd_pkg::ADDR_BITS_NARROW;
         cmd_addr <= 32'h0000_0000;
      end else begin
         if (opcode_done) begin
            cur_cmd <= dec_cmd;
            cur_len <= dec_len;
         end
         if (addr_done) begin
            cmd_addr <= addr_word;
         end
      end
   end

   // Read data: the same register rotates, the address never advances
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rot <= 8'h00;
         o_io_out <= 4'h0;
         o_io_oe <= lock_cmd_pkg::OE_OFF;
      end else begin
         if (addr_done) begin
            rot <= rd_value;
         end else if (rd_shift) begin
            rot <= quad ? {rot[3:0], rot[7:4]} : {rot[6:0], rot[7]};
         end
         if (rd_shift) begin
            o_io_out <= quad ? rot[7:4] : {2'b00, rot[7], 1'b0};
            o_io_oe <= quad ? lock_cmd_pkg::OE_QUAD : lock_cmd_pkg::OE_SINGLE;
         end else if (cs_s) begin
            o_io_oe <= lock_cmd_pkg::OE_OFF;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         status <= '0;
         busy_cmd <= lock_cmd_pkg::CMD_NONE;
         timer <= 16'h0000;
      end else begin
         if (exec_timed) begin
            status.busy <= 1'b1;
            busy_cmd <= cur_cmd;
            timer <= 16'(OP_CYC - 1);
         end else if (op_end) begin
            status.busy <= 1'b0;
         end else if (status.busy) begin
            timer <= 16'(timer - 16'h0001);
         end
         if (exec_write_enable_cmd) begin
            status.write_enable_latch <= 1'b1;
         end else if (ptr_end) begin
            status.write_enable_latch <= 1'b0;
         end
         if (ptr_end && i_ptr_fail) begin
            status.prog_error <= 1'b1;
         end else if (i_error_clear) begin
            status.prog_error <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         lock_bits <= {NUM_SECTORS{lock_cmd_pkg::LOCK_BIT_RESET}};
         o_pointer_region <= lock_cmd_pkg::POINTER_RESET;
      end else if (op_end) begin
         case (busy_cmd)
            lock_cmd_pkg::CMD_LOCK: lock_bits[sec_idx] <= lock_cmd_pkg::LOCKED;
            lock_cmd_pkg::CMD_UNLOCK: lock_bits[sec_idx] <= lock_cmd_pkg::UNLOCKED;
            lock_cmd_pkg::CMD_GLOBAL_LOCK: lock_bits <= {NUM_SECTORS{lock_cmd_pkg::LOCKED}};
            lock_cmd_pkg::CMD_GLOBAL_UNLOCK: lock_bits <= {NUM_SECTORS{lock_cmd_pkg::UNLOCKED}};
            lock_cmd_pkg::CMD_SET_PTR: begin
               if (!i_ptr_fail) begin
                  o_pointer_region <= cmd_addr;
               end
            end
            default: begin
               lock_bits <= lock_bits;
            end
         endcase
      end
   end

   assign o_status = status;
   assign o_lock_bits = lock_bits;

   // Checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_op_end(lock_cmd_pkg::cmd_e c);
      status.busy && (timer == 16'h0000) && (busy_cmd == c);
   endsequence

   sequence s_start;
      cs_rise && (phase == lock_cmd_pkg::PH_DONE) && (cur_cmd != lock_cmd_pkg::CMD_LOCK_RD)
         && (cur_cmd != lock_cmd_pkg::CMD_WRITE_ENABLE);
   endsequence

   a_busy_start: assert property (s_start |=> status.busy)
      else $error("busy not raised after select rise");
   a_busy_length: assert property ($rose(status.busy) |-> ##OP_LAST status.busy ##1 !status.busy)
      else $error("busy length wrong");
   a_busy_gap: assert property (status.busy && (timer != 16'h0000) |=> status.busy)
      else $error("busy dropped early");
   a_lock_clear: assert property (s_op_end(lock_cmd_pkg::CMD_LOCK) |=> !o_lock_bits[sec_idx])
      else $error("sector lock bit not cleared");
   a_unlock_set: assert property (s_op_end(lock_cmd_pkg::CMD_UNLOCK) |=> o_lock_bits[sec_idx])
      else $error("sector lock bit not set");
   a_global_lock: assert property (s_op_end(lock_cmd_pkg::CMD_GLOBAL_LOCK) |=> (o_lock_bits == '0))
      else $error("global lock left bits set");
   a_global_unlock: assert property (s_op_end(lock_cmd_pkg::CMD_GLOBAL_UNLOCK) |=> (&o_lock_bits))
      else $error("global unlock left bits clear");
   a_late_select: assert property (cs_rise && (phase != lock_cmd_pkg::PH_DONE) |=> !$rose(status.busy))
      else $error("operation started without exact select rise");
   a_ptr_needs_wel: assert property ($rose(status.busy) && (busy_cmd == lock_cmd_pkg::CMD_SET_PTR) |-> status.write_enable_latch)
      else $error("pointer set ran without write enable");
   a_ptr_wel_clear: assert property (s_op_end(lock_cmd_pkg::CMD_SET_PTR) |=> !status.write_enable_latch && !status.busy)
      else $error("write enable not cleared after pointer set");
   a_ptr_error: assert property (s_op_end(lock_cmd_pkg::CMD_SET_PTR) and i_ptr_fail |=> status.prog_error)
      else $error("pointer failure not flagged");
   a_read_lines: assert property (rd_shift |=> o_io_oe == (quad ? lock_cmd_pkg::OE_QUAD : lock_cmd_pkg::OE_SINGLE))
      else $error("read data on wrong lines");

endmodule // lock_cmd_engine

`default_nettype wire

// ===== test/spi_host_model.sv
// Host flash controller model driving the serial link of the lock engine
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
   output logic o_sck,
   output logic o_cs_n,
   output logic [3:0] o_io,
   input wire logic [3:0] i_io_out
);
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_io = 4'h5;
   end

   // Sends ntx clocks of tx MSB first, then reads nrx clocks; quad moves a nibble a clock
   task automatic frame(input logic [63:0] tx, input int ntx, input int nrx, input logic quad,
                        output logic [15:0] rx);
      logic [63:0] sh;
      sh = tx;
      rx = 16'h0000;
      #157 o_cs_n = 1'b0;
      for (int k = 0; k < ntx + nrx; k++) begin
         if (k < ntx) begin
            o_io = quad ? sh[63:60] : {~o_io[3:1], sh[63]};
            sh = quad ? sh << 4 : sh << 1;
         end else begin
            o_io = ~o_io;
         end
         #160 o_sck = 1'b1;
         #160;
         if (k >= ntx) begin
            rx = quad ? {rx[11:0], i_io_out} : {rx[14:0], i_io_out[1]};
         end
         o_sck = 1'b0;
      end
      #160 o_cs_n = 1'b1;
      o_io = ~o_io;
   endtask
endmodule // spi_host_model

`default_nettype wire

// ===== test/block_lock_pointer_protect_cmds_tb.sv
// Self-checking bench of the sector lock command engine
`timescale 1ns/1ps
`default_nettype none

module block_lock_pointer_protect_cmds_tb;
   localparam int NS = 16;
   localparam int OPT = 80;
   localparam int OP_CYC = (OPT + 39) / 40;
   logic i_ref_clk, i_rst, i_ptr_fail, i_error_clear, sck, cs_n;
   lock_cmd_pkg::cfg_s i_cfg;
   logic [3:0] host_io, io_wire, o_io_out, o_io_oe;
   lock_cmd_pkg::status_s o_status;
   logic [NS-1:0] o_lock_bits, exp_lock;
   logic [31:0] o_pointer_region, exp_ptr, addr, seed;
   logic [15:0] rx;
   logic [7:0] op;
   logic [3:0] oe_last;
   int mismatches = 0;
   int tests_run = 0;
   int sec;
   logic [7:0] lk_ops [4] = '{8'h36, 8'hE1, 8'h39, 8'hE2};

   assign io_wire = (o_io_oe & o_io_out) | (~o_io_oe & host_io);

   // Remembers which lines the last read frame drove
   always @(posedge i_ref_clk) begin
      if (o_io_oe !== 4'h0) begin
         oe_last <= o_io_oe;
      end
   end

   spi_host_model i_host (.o_sck(sck), .o_cs_n(cs_n), .o_io(host_io), .i_io_out(o_io_out));

   lock_cmd_engine #(.NUM_SECTORS(NS), .SECTOR_SHIFT(16), .OP_TIME_NS(OPT)) i_dut (
      .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_io(io_wire),
      .i_cfg(i_cfg), .i_ptr_fail(i_ptr_fail), .i_error_clear(i_error_clear),
      .o_io_out(o_io_out), .o_io_oe(o_io_oe), .o_status(o_status), .o_lock_bits(o_lock_bits),
      .o_pointer_region(o_pointer_region));

   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic int alen(input logic [7:0] c);
      return (c inside {8'hE0, 8'hE1, 8'hE2, 8'hE3} || i_cfg.addr_wide === 1'b1) ? 32 : 24;
   endfunction

   function automatic logic [7:0] exp_byte(input logic b);
      return b ? lock_cmd_pkg::LOCK_REG_UNLOCKED : lock_cmd_pkg::LOCK_REG_LOCKED;
   endfunction

   task automatic close_out();
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_lock();
      tests_run++;
      if (o_lock_bits !== exp_lock) begin
         mismatches++;
         $display("MISMATCH %0t lock bits got %h exp %h", $time, o_lock_bits, exp_lock);
      end
   endtask

   task automatic chk_stat(input lock_cmd_pkg::status_s exp);
      tests_run++;
      if (o_status !== exp) begin
         mismatches++;
         $display("MISMATCH %0t status got %b exp %b", $time, o_status, exp);
      end
   endtask

   task automatic set_cfg(input logic [6:0] c);
      @(posedge i_ref_clk);
      #1 i_cfg = lock_cmd_pkg::cfg_s'(c);
   endtask

   task automatic run(input logic [7:0] c, input logic [31:0] a, input int al, input int extra,
                      input int nrx);
      logic [63:0] tx;
      int step;
      step = (i_cfg.quad === 1'b1) ? 4 : 1;
      tx = {c, 56'h0} | ({32'h0, a} << (56 - al));
      i_host.frame(tx, (8 + al) / step + extra, nrx / step, i_cfg.quad, rx);
   endtask

   task automatic wait_op(input logic runs);
      int n;
      int w;
      n = 0;
      w = 0;
      while (o_status.busy !== 1'b1 && w < 20) begin
         @(posedge i_ref_clk);
         #1 w++;
      end
      while (o_status.busy === 1'b1 && n < 50) begin
         @(posedge i_ref_clk);
         #1 n++;
      end
      chk32(32'(n), runs ? 32'(OP_CYC) : 32'h0, "busy length");
      repeat (3) @(posedge i_ref_clk);
      #1;
   endtask

   initial begin
      #2000000;
      mismatches++;
      close_out();
   end

   initial begin
      i_rst = 1'b1;
      i_cfg = lock_cmd_pkg::cfg_s'(7'h17);
      i_ptr_fail = 1'b0;
      i_error_clear = 1'b0;
      seed = 32'h1816A55B;
      exp_lock = '1;
      exp_ptr = 32'h0;
      repeat (3) @(posedge i_ref_clk);
      #1 i_rst = 1'b0;
      chk_lock();
      chk_stat(3'b000);
      repeat (6) @(posedge i_ref_clk);
      for (int n = 0; n < 24; n++) begin
         set_cfg({2'(rnd()), 5'h17});
         op = lk_ops[rnd() % 4];
         sec = rnd() % NS;
         run(op, 32'(sec) << 16, alen(op), 0, 0);
         wait_op(1'b1);
         exp_lock[sec] = op inside {8'h36, 8'hE1} ? lock_cmd_pkg::LOCKED : lock_cmd_pkg::UNLOCKED;
         chk_lock();
         op = rnd() % 2 ? lock_cmd_pkg::OP_LOCK_RD : lock_cmd_pkg::OP_LOCK_RD_WIDE;
         run(op, 32'(sec) << 16, alen(op), 0, 16);
         chk32({16'h0, rx}, {16'h0, {2{exp_byte(exp_lock[sec])}}}, "lock read");
         repeat (6) @(posedge i_ref_clk);
         #1 chk32(32'(oe_last), (i_cfg.quad === 1'b1) ? 32'hF : 32'h2, "read lines");
         chk32(32'(o_io_oe), 32'h0, "lines released");
      end
      for (int g = 0; g < 4; g++) begin
         op = g % 2 ? lock_cmd_pkg::OP_GLOBAL_UNLOCK : lock_cmd_pkg::OP_GLOBAL_LOCK;
         run(op, 32'h0, 0, g < 2 ? 1 : 0, 0);
         wait_op(g >= 2);
         if (g >= 2) begin
            exp_lock = g == 2 ? '0 : '1;
         end
         chk_lock();
      end
      set_cfg(7'h07);
      run(lock_cmd_pkg::OP_LOCK_WIDE, 32'h0003_0000, 32, 0, 0);
      wait_op(1'b0);
      chk_lock();
      set_cfg(7'h57);
      run(lock_cmd_pkg::OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
      repeat (10) @(posedge i_ref_clk);
      for (int r = 0; r < 4; r++) begin
         set_cfg(7'h57 ^ (7'h08 >> r));
         run(lock_cmd_pkg::OP_SET_PTR, rnd(), 32, 0, 0);
         wait_op(1'b0);
         chk_stat(3'b010);
      end
      set_cfg(7'h57);
      for (int p = 0; p < 3; p++) begin
         addr = rnd();
         op = p == 1 ? lock_cmd_pkg::OP_SET_PTR : lock_cmd_pkg::OP_SET_PTR_WIDE;
         @(posedge i_ref_clk);
         #1 i_ptr_fail = p == 2;
         if (p != 1) begin
            run(lock_cmd_pkg::OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
            repeat (10) @(posedge i_ref_clk);
         end
         run(op, addr, 32, 0, 0);
         wait_op(p != 1);
         exp_ptr = p == 0 ? addr : exp_ptr;
         chk32(o_pointer_region, exp_ptr, "pointer");
         chk_stat({2'b00, p == 2});
      end
      @(posedge i_ref_clk);
      #1 i_error_clear = 1'b1;
      @(posedge i_ref_clk);
      #1 i_error_clear = 1'b0;
      i_ptr_fail = 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1 chk_stat(3'b000);
      close_out();
   end
endmodule // block_lock_pointer_protect_cmds_tb

`default_nettype wire
